// File: include/tmc_pkg.sv
// Purpose: shared constants and types for the transceiver mode controller
// Assumes: 200 MHz clock, APB3 register access with 32-bit data
// Notes: times are in ns; cycle counts are derived from the clock rate
package tmc_pkg;
  localparam int CLOCK_MHZ = 200;
  // go-to-sleep hold time, a least time, so it rounds up
  localparam int GOTOSLEEP_HOLD_NS = 50000;
  localparam int GOTOSLEEP_HOLD_CYCLES =
    (GOTOSLEEP_HOLD_NS * CLOCK_MHZ + 999) / 1000;
  // bus wake pattern: least phase times round up, window rounds down
  localparam int WAKE_LOW_NS = 1000;
  localparam int WAKE_LOW_CYCLES = (WAKE_LOW_NS * CLOCK_MHZ + 999) / 1000;
  localparam int WAKE_IDLE_NS = 1000;
  localparam int WAKE_IDLE_CYCLES = (WAKE_IDLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int WAKE_TOTAL_NS = 100000;
  localparam int WAKE_TOTAL_CYCLES = (WAKE_TOTAL_NS * CLOCK_MHZ) / 1000;
  localparam int COUNT_W = 16;
  // register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] STATUS_ADDR = 12'h000;
  localparam logic [11:0] CTRL_ADDR = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int CTRL_WAKE_EN_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_WAKE_BIT = 3;
  localparam int ST_IO_LOW_BIT = 4;
  localparam int ST_BAT_LOW_BIT = 5;
  localparam int ST_CORE_LOW_BIT = 6;
  localparam int ST_POWER_ON_BIT = 7;
  localparam int ST_TX_EN_BIT = 8;
  typedef enum logic [2:0] {
    NORMAL, RX_ONLY, STANDBY, GO_TO_SLEEP, SLEEP
  } mode_t;
  typedef enum logic [2:0] {
    W_IDLE, W_LOW1, W_GAP, W_LOW2, W_TAIL
  } wake_state_t;
endpackage : tmc_pkg

// File: include/wake_if.sv
// Purpose: link between the mode controller and the bus wake detector
// Assumes: single clock domain
// Notes: detected is a one-cycle pulse
`timescale 1ns/1ps
interface wake_if;
  logic enable;
  logic data0;
  logic detected;
  modport detector (input enable, input data0, output detected);
  modport controller (output enable, output data0, input detected);
endinterface : wake_if

// File: rtl/bus_wake_detector.sv
// Purpose: recognise the two-low-phase bus wake pattern
// Assumes: data0 is the low-power receiver's DATA_0 indication
// Notes: the whole pattern must fit in the total window
`timescale 1ns/1ps
module bus_wake_detector #(
  parameter int LOW_CYCLES = tmc_pkg::WAKE_LOW_CYCLES,
  parameter int IDLE_CYCLES = tmc_pkg::WAKE_IDLE_CYCLES,
  parameter int TOTAL_CYCLES = tmc_pkg::WAKE_TOTAL_CYCLES,
  parameter int COUNT_W = tmc_pkg::COUNT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // controller side
  wake_if.detector wake
);
  tmc_pkg::wake_state_t state, next_state;
  logic [COUNT_W-1:0] phaseCount, next_phaseCount;
  logic [COUNT_W-1:0] totalCount, next_totalCount;
  logic detected, next_detected;
  wire lowLong = phaseCount >= COUNT_W'(LOW_CYCLES);
  wire idleLong = phaseCount >= COUNT_W'(IDLE_CYCLES);
  wire tailDone = phaseCount + COUNT_W'(1) >= COUNT_W'(IDLE_CYCLES);
  wire timeUp = totalCount >= COUNT_W'(TOTAL_CYCLES);

  // phase sequencer; a short low drops back to idle, a short gap restarts at the first low [R21]
  always_comb begin
    next_state = state;
    next_phaseCount = phaseCount + COUNT_W'(1);
    next_totalCount = totalCount + COUNT_W'(1);
    next_detected = 1'b0;
    case (state)
      tmc_pkg::W_IDLE: begin
        next_totalCount = COUNT_W'(1);
        next_phaseCount = COUNT_W'(1);
        if (wake.data0) next_state = tmc_pkg::W_LOW1;
      end
      tmc_pkg::W_LOW1, tmc_pkg::W_LOW2: begin
        if (!wake.data0) begin
          next_phaseCount = COUNT_W'(1);
          if (!lowLong) next_state = tmc_pkg::W_IDLE;
          else if (state == tmc_pkg::W_LOW1) next_state = tmc_pkg::W_GAP;
          else next_state = tmc_pkg::W_TAIL;
        end
      end
      tmc_pkg::W_GAP: begin
        if (wake.data0) begin
          next_phaseCount = COUNT_W'(1);
          if (idleLong) begin
            next_state = tmc_pkg::W_LOW2;
          end else begin
            // gap too short: this low may itself start a pattern
            next_state = tmc_pkg::W_LOW1;
            next_totalCount = COUNT_W'(1);
          end
        end
      end
      tmc_pkg::W_TAIL: begin
        if (wake.data0) begin
          next_state = tmc_pkg::W_IDLE;
        end else if (tailDone) begin
          next_state = tmc_pkg::W_IDLE;
          next_detected = 1'b1; // [R21]
        end
      end
      default: next_state = tmc_pkg::W_IDLE;
    endcase
    // the window bounds the whole pattern [R21]
    if (!wake.enable || (state != tmc_pkg::W_IDLE && timeUp)) begin
      next_state = tmc_pkg::W_IDLE;
      next_detected = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= tmc_pkg::W_IDLE;
      phaseCount <= '0;
      totalCount <= '0;
      detected <= 1'b0;
    end else begin
      state <= next_state;
      phaseCount <= next_phaseCount;
      totalCount <= next_totalCount;
      detected <= next_detected;
    end
  end

  assign wake.detected = detected;
endmodule : bus_wake_detector

// File: rtl/transceiver_mode_controller.sv
// Purpose: operating-mode state machine of a bus node transceiver
// Assumes: undervoltage detector inputs are already filtered levels
// Notes: registers over APB3, one wait state on every access
`timescale 1ns/1ps
// Notes on behaviour
// R1: mode-select and enable pins pick the operating mode.
// R2: io or battery undervoltage forces Sleep, overruling core undervoltage.
// R3: core undervoltage in Normal or Receive-only forces Standby.
// R4: any undervoltage flag being set clears the wake flag.
// R5: battery recovery in Sleep sets wake, enters pin mode; Normal clears it.
// R6: io recovery in Sleep keeps wake; mode-select high picks normal modes.
// R7: Normal mode drives and receives; receiver output goes to receive data.
// R8: transmitter needs no timeouts and no overheat, else stays disabled.
// R9: guardian low or transmit-enable high disables the transmitter.
// R10: enabled with data high drives plus high, minus low.
// R11: enabled with data low drives plus low, minus high.
// R12: Receive-only keeps the transmitter off whatever the enables.
// R13: inhibit output high except Sleep, where it floats.
// R14: Standby and Go-to-sleep only run the low-power wake receiver.
// R15: in low-power modes receive pins show low when wake is set.
// R16: Go-to-sleep held past hold time with wake clear enters Sleep.
// R17: mode-select rise during undervoltage sets wake if supplies present.
// R18: setting wake clears undervoltage flags; io present follows the pins.
// R19: Sleep with wake set goes to Standby or Go-to-sleep by enable; the code enters Standby whatever the enable when io is absent.
// R20: without undervoltage the mode follows the pins at once.
// R21: bus wake needs two long lows, gaps, all inside the window.
// R22: mode-select rise sets wake; entering Normal clears it at once.
// R23: wake clears entering Normal, a low-power mode, or on undervoltage.
module transceiver_mode_controller #(
  parameter int HOLD_CYCLES = tmc_pkg::GOTOSLEEP_HOLD_CYCLES,
  parameter int WAKE_TOTAL_CYCLES = tmc_pkg::WAKE_TOTAL_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // APB3 slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host mode and transmit pins
  input wire logic modeSelectLow,
  input wire logic enable,
  input wire logic txDriveEnableN,
  input wire logic guardianEnable,
  input wire logic txData,
  // supply and fault monitors
  input wire logic ioSupplyLow,
  input wire logic batteryLow,
  input wire logic coreSupplyLow,
  input wire logic txTimeout,
  input wire logic guardianTimeout,
  input wire logic overheat,
  // receivers
  input wire logic busRxData,
  input wire logic busActivity,
  input wire logic busData0,
  // host receive pins
  output logic rxDataOut,
  output logic rxActivityN,
  // bus driver
  output logic busPlus,
  output logic busMinus,
  output logic busDriveEnable,
  // inhibit pin
  output logic supplyInhibitOut,
  output logic supplyInhibitOe
);
  tmc_pkg::mode_t mode, next_mode, pinMode;
  logic wakeFlag, next_wakeFlag;
  logic ioSupplyLowFlag, batteryLowFlag, coreSupplyLowFlag;
  logic next_ioFlag, next_batFlag, next_coreFlag;
  logic powerOnFlag;
  logic prevModeSelectLow, prevIoLow, prevBatLow, prevCoreLow;
  logic [tmc_pkg::COUNT_W-1:0] holdCount;
  logic [31:0] ctrl;
  wake_if wakeBus ();

  // pin decode [R1]
  always_comb begin
    case ({modeSelectLow, enable})
      2'b11: pinMode = tmc_pkg::NORMAL;
      2'b10: pinMode = tmc_pkg::RX_ONLY;
      2'b01: pinMode = tmc_pkg::GO_TO_SLEEP;
      default: pinMode = tmc_pkg::STANDBY;
    endcase
  end

  // mode classes
  wire lowPower = mode == tmc_pkg::STANDBY || mode == tmc_pkg::GO_TO_SLEEP
    || mode == tmc_pkg::SLEEP;
  wire nextLowPower = next_mode == tmc_pkg::STANDBY
    || next_mode == tmc_pkg::GO_TO_SLEEP || next_mode == tmc_pkg::SLEEP;
  wire pinLowPower = pinMode == tmc_pkg::STANDBY
    || pinMode == tmc_pkg::GO_TO_SLEEP;

  // undervoltage events: flags set on the falling supply, not on the level,
  // so a flag cleared by wake stays clear until the next dip
  wire ioSet = ioSupplyLow && !prevIoLow;
  wire batSet = batteryLow && !prevBatLow;
  wire coreSet = coreSupplyLow && !prevCoreLow;
  wire anyUvSet = ioSet || batSet || coreSet;
  wire ioRecover = ioSupplyLowFlag && !ioSupplyLow;
  wire batRecover = batteryLowFlag && !batteryLow;
  wire ioPresent = !ioSupplyLow;

  // wake sources; an undervoltage in the same cycle wins [R4]
  wire modeSelectRise = modeSelectLow && !prevModeSelectLow;
  wire pinWake = modeSelectRise && ioPresent
    && (!coreSupplyLow || !batteryLow); // [R17] [R22]
  wire busWake = wakeBus.detected && lowPower;
  wire wakeEvent = (pinWake || busWake || batRecover) && !anyUvSet; // [R5]

  // go-to-sleep hold tracking
  wire holdDone = holdCount >= tmc_pkg::COUNT_W'(HOLD_CYCLES);
  wire holding = mode == tmc_pkg::GO_TO_SLEEP
    && pinMode == tmc_pkg::GO_TO_SLEEP;

  // undervoltage flags: set wins, wake clears them [R18]
  assign next_ioFlag = ioSet || (ioSupplyLowFlag && ioSupplyLow && !wakeEvent);
  assign next_batFlag = batSet || (batteryLowFlag && batteryLow && !wakeEvent);
  assign next_coreFlag = coreSet
    || (coreSupplyLowFlag && coreSupplyLow && !wakeEvent);

  // mode sequencing, undervoltage entries first
  always_comb begin
    next_mode = mode;
    if (ioSet || batSet) begin
      next_mode = tmc_pkg::SLEEP; // [R2]
    end else if (coreSet) begin
      if (!lowPower) next_mode = tmc_pkg::STANDBY; // [R3]
    end else if (wakeEvent) begin
      if (ioPresent) next_mode = pinMode; // [R18] [R5]
      else if (mode == tmc_pkg::SLEEP) next_mode = tmc_pkg::STANDBY; // [R19]
    end else if (ioRecover && mode == tmc_pkg::SLEEP) begin
      if (modeSelectLow) next_mode = pinMode; // [R6]
    end else if (!ioSupplyLowFlag && !batteryLowFlag && mode != tmc_pkg::SLEEP)
    begin
      if (holding && holdDone && !wakeFlag) begin
        next_mode = tmc_pkg::SLEEP; // [R16]
      end else if (!coreSupplyLowFlag || pinLowPower) begin
        // a core dip only permits the low-power pin modes
        next_mode = pinMode; // [R20]
      end
    end
  end

  // wake flag; an undervoltage or entry to Normal beats a set in the same cycle
  always_comb begin
    next_wakeFlag = wakeFlag;
    if (anyUvSet) begin
      next_wakeFlag = 1'b0; // [R4] [R23]
    end else if (wakeEvent) begin
      next_wakeFlag = next_mode != tmc_pkg::NORMAL; // [R22] [R5]
    end else if (next_mode != mode && (next_mode == tmc_pkg::NORMAL
      || (nextLowPower && !lowPower))) begin
      next_wakeFlag = 1'b0; // [R23]
    end
  end

  // mode, wake and undervoltage flags
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode <= tmc_pkg::STANDBY;
      wakeFlag <= 1'b0;
      ioSupplyLowFlag <= 1'b0;
      batteryLowFlag <= 1'b0;
      coreSupplyLowFlag <= 1'b0;
    end else begin
      mode <= next_mode;
      wakeFlag <= next_wakeFlag;
      ioSupplyLowFlag <= next_ioFlag;
      batteryLowFlag <= next_batFlag;
      coreSupplyLowFlag <= next_coreFlag;
    end
  end

  // previous pin levels; reset to the quiet level to avoid a false edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prevModeSelectLow <= 1'b1;
      prevIoLow <= 1'b0;
      prevBatLow <= 1'b0;
      prevCoreLow <= 1'b0;
    end else begin
      prevModeSelectLow <= modeSelectLow;
      prevIoLow <= ioSupplyLow;
      prevBatLow <= batteryLow;
      prevCoreLow <= coreSupplyLow;
    end
  end

  // hold timer saturates so it cannot wrap back below the limit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) holdCount <= '0;
    else if (!holding) holdCount <= '0;
    else if (!holdDone) holdCount <= holdCount + tmc_pkg::COUNT_W'(1); // [R16]
  end

  // power-on flag: set by reset, cleared once Normal is reached
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) powerOnFlag <= 1'b1;
    else if (mode == tmc_pkg::NORMAL) powerOnFlag <= 1'b0;
  end

  // transmitter gating [R8] [R9] [R12]
  wire txAllowed = mode == tmc_pkg::NORMAL && !txTimeout
    && !guardianTimeout && !overheat;
  wire txOn = txAllowed && guardianEnable && !txDriveEnableN;

  // receive pins: live receiver in normal modes, wake flag otherwise
  wire rxDataNext = lowPower ? !wakeFlag : busRxData; // [R7] [R15]
  wire rxActivityNext = lowPower ? !wakeFlag : !busActivity; // [R15]

  // pin outputs; one cycle of latency buys glitch-free pins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busDriveEnable <= 1'b0;
      busPlus <= 1'b0;
      busMinus <= 1'b0;
      rxDataOut <= 1'b1;
      rxActivityN <= 1'b1;
      supplyInhibitOut <= 1'b1;
      supplyInhibitOe <= 1'b1;
    end else begin
      busDriveEnable <= txOn; // [R9] [R12]
      busPlus <= txOn && txData; // [R10] [R11]
      busMinus <= txOn && !txData; // [R10] [R11]
      rxDataOut <= rxDataNext; // [R7]
      rxActivityN <= rxActivityNext;
      supplyInhibitOut <= 1'b1;
      supplyInhibitOe <= next_mode != tmc_pkg::SLEEP; // [R13] [R19]
    end
  end

  // bus wake detector only listens in low-power modes [R14]
  assign wakeBus.enable = lowPower && ctrl[tmc_pkg::CTRL_WAKE_EN_BIT];
  assign wakeBus.data0 = busData0;

  bus_wake_detector #(
    .LOW_CYCLES(tmc_pkg::WAKE_LOW_CYCLES),
    .IDLE_CYCLES(tmc_pkg::WAKE_IDLE_CYCLES),
    .TOTAL_CYCLES(WAKE_TOTAL_CYCLES),
    .COUNT_W(tmc_pkg::COUNT_W)
  ) wakeDetector (
    .clock(clock),
    .reset_n(reset_n),
    .wake(wakeBus.detector)
  );

  // APB decode: first access cycle prepares, second completes
  wire apbFirst = psel && penable && !pready;
  wire apbDone = psel && penable && pready;
  wire statusHit = paddr == tmc_pkg::STATUS_ADDR;
  wire ctrlHit = paddr == tmc_pkg::CTRL_ADDR;
  wire mapped = statusHit || ctrlHit;

  // status fields sit at their package bit positions; spare bits read 0
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[tmc_pkg::ST_MODE_LSB +: 3] = mode;
    statusWord[tmc_pkg::ST_WAKE_BIT] = wakeFlag;
    statusWord[tmc_pkg::ST_IO_LOW_BIT] = ioSupplyLowFlag;
    statusWord[tmc_pkg::ST_BAT_LOW_BIT] = batteryLowFlag;
    statusWord[tmc_pkg::ST_CORE_LOW_BIT] = coreSupplyLowFlag;
    statusWord[tmc_pkg::ST_POWER_ON_BIT] = powerOnFlag;
    statusWord[tmc_pkg::ST_TX_EN_BIT] = txOn;
  end

  // read select; unmapped offsets read 0 and raise the error flag
  wire [31:0] readWord = statusHit ? statusWord :
    ctrlHit ? ctrl : 32'h00000000;

  // APB answer registers
  // pready falls the cycle after it rises, so a held access completes every second cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apbFirst;
      pslverr <= apbFirst && !mapped;
      prdata <= (apbFirst && !pwrite) ? readWord : 32'h00000000;
    end
  end

  // control register; only the low bit is implemented
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ctrl <= tmc_pkg::CTRL_RESET;
    else if (apbDone && pwrite && ctrlHit) ctrl <= {31'h00000000, pwdata[0]};
  end
endmodule : transceiver_mode_controller

// File: testbench/host_pin_model.sv
// Purpose: host side of the mode and transmit pins
// Assumes: tasks are called just after a rising edge of clock
// Notes: after the power-up values, pins change only by non-blocking assignment after an edge
`timescale 1ns/1ps
module host_pin_model (
  // clock
  input wire logic clock,
  // pins towards the controller
  output logic modeSelectLow,
  output logic enable,
  output logic txDriveEnableN,
  output logic guardianEnable,
  output logic txData
);
  // power up asking for Standby with the transmitter idle
  initial begin
    modeSelectLow = 1'b0;
    enable = 1'b0;
    txDriveEnableN = 1'b1;
    guardianEnable = 1'b0;
    txData = 1'b1;
  end
  // pin pair for each selectable mode
  task automatic set_mode(input tmc_pkg::mode_t m);
    @(posedge clock);
    modeSelectLow <= (m == tmc_pkg::NORMAL || m == tmc_pkg::RX_ONLY);
    enable <= (m == tmc_pkg::NORMAL || m == tmc_pkg::GO_TO_SLEEP);
  endtask : set_mode
  // transmit pins change together so no half-set combination shows
  task automatic set_tx(input logic g, input logic n, input logic d);
    @(posedge clock);
    guardianEnable <= g;
    txDriveEnableN <= n;
    txData <= d;
  endtask : set_tx
  // one low cycle then high gives the rising edge that asks for a wake
  task automatic raise_select(input logic en);
    @(posedge clock);
    modeSelectLow <= 1'b0;
    enable <= en;
    @(posedge clock);
    modeSelectLow <= 1'b1;
  endtask : raise_select
endmodule : host_pin_model

// File: testbench/mode_controller_properties.sv
// Purpose: port-level properties of the mode controller
// Assumes: bound to every transceiver_mode_controller
// Notes: pin-driven checks wait four samples, longer than the two-register pin latency
`timescale 1ns/1ps
module mode_controller_properties #(
  parameter int HOLD_CYCLES = 20,
  parameter int WAKE_TOTAL_CYCLES = 1500
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // host pins
  input wire logic modeSelectLow,
  input wire logic enable,
  input wire logic txDriveEnableN,
  input wire logic guardianEnable,
  // monitors
  input wire logic ioSupplyLow,
  input wire logic batteryLow,
  input wire logic coreSupplyLow,
  input wire logic txTimeout,
  input wire logic guardianTimeout,
  input wire logic overheat,
  // outputs
  input wire logic rxDataOut,
  input wire logic rxActivityN,
  input wire logic busPlus,
  input wire logic busMinus,
  input wire logic busDriveEnable,
  input wire logic supplyInhibitOut,
  input wire logic supplyInhibitOe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // fault summaries
  wire logic txFault = txTimeout || guardianTimeout || overheat;
  wire logic uvAny = ioSupplyLow || batteryLow || coreSupplyLow;
  inhibit_high_a: assert property (supplyInhibitOut)
    else $error("inhibit output not high");
  drive_blocked_a: assert property ((!guardianEnable || txDriveEnableN)[*4]
    |-> !busDriveEnable) else $error("driving while disabled");
  drive_levels_a: assert property (busDriveEnable |-> busPlus != busMinus)
    else $error("bus lines not opposite");
  drive_off_a: assert property (!busDriveEnable |-> !busPlus && !busMinus)
    else $error("bus line high while off");
  supply_sleep_a: assert property ($rose(ioSupplyLow || batteryLow)
    |-> ##[1:3] !supplyInhibitOe) else $error("no sleep on uv");
  core_stop_a: assert property ($rose(coreSupplyLow) && busDriveEnable
    |-> ##[1:3] !busDriveEnable) else $error("core uv kept tx");
  rx_only_a: assert property ((modeSelectLow && !enable)[*4]
    |-> !busDriveEnable) else $error("receive-only drove");
  faults_block_a: assert property (txFault[*4] |-> !busDriveEnable)
    else $error("transmit despite fault");
  low_power_a: assert property ((!modeSelectLow)[*4] |->
    rxDataOut == rxActivityN && !busDriveEnable)
    else $error("low-power receive pins differ");
  normal_drive_a: assert property ((modeSelectLow && enable && guardianEnable
    && !txDriveEnableN && !txFault && !uvAny)[*4] |-> busDriveEnable)
    else $error("normal mode not driving");
  // main scenarios reached
  sleep_c: cover property ($fell(supplyInhibitOe));
  drive_c: cover property (busDriveEnable && busPlus);
  wake_c: cover property (!rxActivityN && !modeSelectLow);
endmodule : mode_controller_properties

bind transceiver_mode_controller mode_controller_properties #(
  .HOLD_CYCLES(HOLD_CYCLES),
  .WAKE_TOTAL_CYCLES(WAKE_TOTAL_CYCLES)
) props (
  .clock, .reset_n, .modeSelectLow, .enable, .txDriveEnableN,
  .guardianEnable, .ioSupplyLow, .batteryLow, .coreSupplyLow, .txTimeout,
  .guardianTimeout, .overheat, .rxDataOut, .rxActivityN, .busPlus,
  .busMinus, .busDriveEnable, .supplyInhibitOut, .supplyInhibitOe
);

// File: testbench/testbench.sv
// Purpose: directed tests of the transceiver mode controller
// Assumes: host_pin_model drives the mode and transmit pins
// Notes: short hold and window counts keep the run brief
`timescale 1ns/1ps
module testbench;
  localparam int HOLD = 20;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic modeSelectLow, enable, txDriveEnableN, guardianEnable, txData;
  logic ioSupplyLow = 1'b0, batteryLow = 1'b0, coreSupplyLow = 1'b0;
  logic txTimeout = 1'b0, guardianTimeout = 1'b0, overheat = 1'b0;
  logic busRxData = 1'b0, busActivity = 1'b0, busData0 = 1'b0;
  logic rxDataOut, rxActivityN, busPlus, busMinus, busDriveEnable;
  logic supplyInhibitOut, supplyInhibitOe;
  int n_errors = 0, checks = 0, cycles = 0;
  tmc_pkg::mode_t seq [5] = '{tmc_pkg::NORMAL, tmc_pkg::RX_ONLY,
    tmc_pkg::GO_TO_SLEEP, tmc_pkg::STANDBY, tmc_pkg::RX_ONLY};
  logic [4:0] wk = 5'h10;
  always #2.5 clock = ~clock;
  transceiver_mode_controller #(
    .HOLD_CYCLES(HOLD),
    .WAKE_TOTAL_CYCLES(1500)
  ) DUT (
    .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .modeSelectLow, .enable,
    .txDriveEnableN, .guardianEnable, .txData, .ioSupplyLow,
    .batteryLow, .coreSupplyLow, .txTimeout, .guardianTimeout,
    .overheat, .busRxData, .busActivity, .busData0, .rxDataOut,
    .rxActivityN, .busPlus, .busMinus, .busDriveEnable,
    .supplyInhibitOut, .supplyInhibitOe
  );
  host_pin_model host (
    .clock, .modeSelectLow, .enable, .txDriveEnableN, .guardianEnable,
    .txData
  );
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask : step
  // one APB transfer; the wait is open, the watchdog catches hangs
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // mode, wake and the three undervoltage flags {core, battery, io}
  task automatic check_status(input tmc_pkg::mode_t m, input logic w,
    input logic [2:0] f);
    apb(1'b0, tmc_pkg::STATUS_ADDR, 32'h0);
    cmp({25'h0, rd[6:0]}, {25'h0, f, w, m});
  endtask : check_status
  // DATA_0 phase of given length, then gap, DATA_0 and idle tail
  task automatic pattern(input int first);
    busData0 <= 1'b1;
    step(first);
    busData0 <= 1'b0;
    step(205);
    busData0 <= 1'b1;
    step(205);
    busData0 <= 1'b0;
    step(210);
  endtask : pattern
  // a hang ends the run through the same report
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    step(16);
    reset_n <= 1'b1;
    apb(1'b0, tmc_pkg::CTRL_ADDR, 32'h0);
    cmp(rd, tmc_pkg::CTRL_RESET);
    cmp_bit(err, 1'b0);
    // reset status: Standby, power-on set, everything else clear
    apb(1'b0, tmc_pkg::STATUS_ADDR, 32'h0);
    cmp(rd, 32'h00000082);
    apb(1'b1, tmc_pkg::CTRL_ADDR, 32'h0);
    apb(1'b0, tmc_pkg::CTRL_ADDR, 32'h0);
    cmp(rd, 32'h00000000);
    apb(1'b1, tmc_pkg::CTRL_ADDR, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    cmp_bit(err, 1'b1);
    cmp(rd, 32'h0);
    $display("registers done");
    for (int i = 0; i < 5; i++) begin
      host.set_mode(seq[i]);
      step(4);
      check_status(seq[i], wk[i], 3'h0);
    end
    $display("pin modes done");
    host.set_mode(tmc_pkg::NORMAL);
    for (int i = 0; i < 8; i++) begin
      host.set_tx(i[2], i[1], i[0]);
      busRxData <= i[0];
      busActivity <= i[1];
      step(4);
      cmp_bit(busDriveEnable, i[2] & ~i[1]);
      cmp_bit(busPlus, i[2] & ~i[1] & i[0]);
      cmp_bit(busMinus, i[2] & ~i[1] & ~i[0]);
      cmp_bit(rxDataOut, i[0]);
      cmp_bit(rxActivityN, ~i[1]);
    end
    host.set_tx(1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      {overheat, txTimeout, guardianTimeout} <= 3'b100 >> i;
      step(4);
      cmp_bit(busDriveEnable, i == 3);
    end
    host.set_mode(tmc_pkg::RX_ONLY);
    step(4);
    cmp_bit(busDriveEnable, 1'b0);
    $display("transmitter done");
    host.set_mode(tmc_pkg::NORMAL);
    step(4);
    coreSupplyLow <= 1'b1;
    step(4);
    check_status(tmc_pkg::STANDBY, 1'b0, 3'b100);
    host.raise_select(1'b0);
    step(4);
    check_status(tmc_pkg::RX_ONLY, 1'b1, 3'h0);
    coreSupplyLow <= 1'b0;
    host.set_mode(tmc_pkg::STANDBY);
    step(4);
    cmp_bit(rxActivityN, 1'b1);
    // with bus wake disabled a full pattern must not wake
    apb(1'b1, tmc_pkg::CTRL_ADDR, 32'h0);
    pattern(205);
    cmp_bit(rxActivityN, 1'b1);
    apb(1'b1, tmc_pkg::CTRL_ADDR, 32'h1);
    pattern(150);
    cmp_bit(rxActivityN, 1'b1);
    pattern(205);
    cmp_bit(rxDataOut, 1'b0);
    cmp_bit(rxActivityN, 1'b0);
    $display("core and bus wake done");
    host.set_mode(tmc_pkg::GO_TO_SLEEP);
    step(HOLD + 10);
    cmp_bit(supplyInhibitOe, 1'b1);
    host.set_mode(tmc_pkg::NORMAL);
    step(4);
    host.set_mode(tmc_pkg::GO_TO_SLEEP);
    step(HOLD - 4);
    cmp_bit(supplyInhibitOe, 1'b1);
    step(14);
    cmp_bit(supplyInhibitOe, 1'b0);
    cmp_bit(supplyInhibitOut, 1'b1);
    check_status(tmc_pkg::SLEEP, 1'b0, 3'h0);
    pattern(205);
    step(4);
    check_status(tmc_pkg::GO_TO_SLEEP, 1'b1, 3'h0);
    cmp_bit(supplyInhibitOe, 1'b1);
    $display("sleep done");
    host.set_mode(tmc_pkg::NORMAL);
    step(4);
    ioSupplyLow <= 1'b1;
    step(4);
    check_status(tmc_pkg::SLEEP, 1'b0, 3'b001);
    host.set_mode(tmc_pkg::RX_ONLY);
    ioSupplyLow <= 1'b0;
    step(4);
    check_status(tmc_pkg::RX_ONLY, 1'b0, 3'h0);
    host.set_mode(tmc_pkg::NORMAL);
    step(4);
    {batteryLow, coreSupplyLow} <= 2'b11;
    step(4);
    apb(1'b0, tmc_pkg::STATUS_ADDR, 32'h0);
    cmp({26'h0, rd[5:0]}, {26'h0, 3'b100, tmc_pkg::SLEEP});
    coreSupplyLow <= 1'b0;
    host.set_mode(tmc_pkg::RX_ONLY);
    batteryLow <= 1'b0;
    step(4);
    check_status(tmc_pkg::RX_ONLY, 1'b1, 3'h0);
    $display("supply faults done");
    end_of_test();
  end
endmodule : testbench
